// *** pkg/scl_map.svh ***
// Constants of the scalar control loop unit: instruction fields, opcodes, bus map.
// Assumes inclusion by bare name from the design files and the package.
`ifndef SCL_MAP_SVH
`define SCL_MAP_SVH

// ****************************************
// Instruction word layout (32-bit word)
// ****************************************
`define OPC_HI 31
`define OPC_LO 27
`define PRI_HI 26
`define PRI_LO 23
`define IDX_HI 22
`define IDX_LO 19
`define ADR_HI 19
`define ADR_LO 0
`define LIT_HI 15
`define LIT_LO 0
`define CNT_HI 18
`define CNT_LO 8
`define LEN_HI 7
`define LEN_LO 0

// ****************************************
// Opcodes
// ****************************************
`define OP_REPEAT 5'h01
`define OP_JUMP 5'h02
`define OP_ENTRY 5'h03
`define OP_RETURN 5'h04
`define OP_XNOR_REGS 5'h05
`define OP_XNOR_LIT 5'h06
`define OP_PLUS_ONE 5'h07
`define OP_MINUS_ONE 5'h08

// ****************************************
// Limits
// ****************************************
`define MAX_BODY 9'h100
`define MOD_MAX 4'hD
`define PC_W 20

// ****************************************
// Register bus map (word byte addresses)
// ****************************************
`define A_CTRL 8'h00
`define A_INSN 8'h04
`define A_PC 8'h08
`define A_STAT 8'h0C
`define A_MASK 8'h10
`define A_BLKLO 8'h14
`define A_BLKHI 8'h18
`define A_LOOP 8'h1C
`define A_REGS 8'h40
`define REGS_SPAN 8'h40

// Status bits: loop error, jump range error, carry, overflow, loop end.
`define ST_NEST 0
`define ST_RANGE 1
`define ST_CARRY 2
`define ST_OVERFLOW_FLAG 3
`define ST_LOOPEND 4
`define ST_W 5
`endif

// *** pkg/scl_pkg.sv ***
// Types shared by the scalar control loop unit.
// Assumes scl_map.svh is on the include path.
`include "scl_map.svh"
package scl_pkg;
  typedef enum logic [1:0] {
    IDLE,
    LOOPING
  } loop_state_t;
  typedef logic [31:0] word_t;
  typedef logic [`PC_W-1:0] pc_t;
endpackage

// *** design/scl_alu.sv ***
// Scalar arithmetic for the control unit: xnor forms and +1 / -1 with flags.
// Assumes operands come from the register file; purely combinational.
`timescale 1ns/1ps
`include "scl_map.svh"
module scl_alu (
  input wire logic [4:0] opcode,
  input wire logic [31:0] opA,
  input wire logic [31:0] opB,
  input wire logic [15:0] literal,
  output logic [31:0] result,
  output logic carry,
  output logic overflow,
  output logic writes
);
  logic [32:0] sum;

  // Unsigned 33-bit arithmetic gives carry for +1; -1 sets carry when the operand is nonzero; signed overflow from sign bits.
  always_comb begin
    sum = 33'h0;
    result = opA;
    carry = 1'b0;
    overflow = 1'b0;
    writes = 1'b0;
    case (opcode)
      `OP_XNOR_REGS: begin
        result = ~(opA ^ opB);
        writes = 1'b1;
      end
      `OP_XNOR_LIT: begin
        result = ~(opA ^ {16'h0000, literal});
        writes = 1'b1;
      end
      `OP_PLUS_ONE: begin
        sum = {1'b0, opA} + 33'h000000001;
        result = sum[31:0];
        carry = sum[32];
        overflow = ~opA[31] & sum[31];
        writes = 1'b1;
      end
      `OP_MINUS_ONE: begin
        sum = {1'b0, opA} - 33'h000000001;
        result = sum[31:0];
        carry = (opA != 32'h00000000);
        overflow = opA[31] & ~sum[31];
        writes = 1'b1;
      end
      default: begin
        writes = 1'b0;
      end
    endcase
  end
endmodule

// *** design/scalar_control_loop_unit.sv ***
// Scalar controller: executes one instruction per push, runs repeat loops, jumps.
// Assumes software feeds instructions over classic Wishbone, one per write.
`timescale 1ns/1ps
`include "scl_map.svh"

module scalar_control_loop_unit (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  output logic [19:0] pcOut
);
  // ****************************************
  // State
  // ****************************************
  logic [31:0] regs_q [0:15];
  logic [31:0] regWrData;
  logic [3:0] regWrSel;
  logic regWr;
  logic [19:0] pc_q, pc_d;
  logic [19:0] blkLo_q, blkLo_d, blkHi_q, blkHi_d;
  logic [`ST_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic carry_q, carry_d, overflow_flag_q, overflow_flag_d;
  scl_pkg::loop_state_t loop_q, loop_d;
  logic [19:0] bodyStart_q, bodyStart_d, bodyEnd_q, bodyEnd_d;
  logic [31:0] passLeft_q, passLeft_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic irq_q, irq_d;

  // ****************************************
  // Bus decode and instruction fields
  // ****************************************
  logic req, wr, insnPush;
  logic [31:0] insn;
  logic [4:0] opc;
  logic [3:0] priSel, idxSel;
  logic [31:0] priVal, idxVal;
  logic [31:0] aluRes;
  logic aluC, aluV, aluW;

  // A new request is one not yet answered; ack drops the cycle after it rises.
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i & (wb_sel_i == 4'hF);
  assign insnPush = wr & (wb_adr_i == `A_INSN);
  assign insn = wb_dat_i;
  assign opc = insn[`OPC_HI:`OPC_LO];
  assign priSel = insn[`PRI_HI:`PRI_LO];
  assign idxSel = insn[`IDX_HI:`IDX_LO];
  assign priVal = regs_q[priSel];
  assign idxVal = regs_q[idxSel];

  scl_alu u_alu (
    .opcode(opc),
    .opA(priVal),
    .opB(idxVal),
    .literal(insn[`LIT_HI:`LIT_LO]),
    .result(aluRes),
    .carry(aluC),
    .overflow(aluV),
    .writes(aluW)
  );

  // ****************************************
  // Instruction execution
  // ****************************************
  logic [19:0] target;
  logic isJump, inRange, modOk;
  logic [31:0] passes;
  logic [`ST_W-1:0] events;

  // Next state of pc, loop, flags and register write for a pushed instruction.
  always_comb begin
    pc_d = pc_q;
    loop_d = loop_q;
    bodyStart_d = bodyStart_q;
    bodyEnd_d = bodyEnd_q;
    passLeft_d = passLeft_q;
    carry_d = carry_q;
    overflow_flag_d = overflow_flag_q;
    regWr = 1'b0;
    regWrSel = priSel;
    regWrData = aluRes;
    events = '0;
    target = insn[`ADR_HI:`ADR_LO];
    isJump = 1'b0;
    modOk = (idxSel != 4'h0) && (idxSel <= `MOD_MAX);
    passes = {21'h0, insn[`CNT_HI:`CNT_LO]};
    case (opc)
      `OP_JUMP: begin
        isJump = 1'b1;
        target = insn[`ADR_HI:`ADR_LO] + (modOk ? idxVal[19:0] : 20'h0);
      end
      `OP_ENTRY: begin
        isJump = 1'b1;
      end
      `OP_RETURN: begin
        isJump = 1'b1;
        target = priVal[19:0] + insn[`ADR_HI:`ADR_LO];
      end
      default: begin
        isJump = 1'b0;
      end
    endcase
    inRange = (target >= blkLo_q) && (target <= blkHi_q);
    if (insnPush) begin
      pc_d = pc_q + 20'h00001;
      if (opc == `OP_REPEAT) begin
        if (loop_q == scl_pkg::LOOPING) begin
          events[`ST_NEST] = 1'b1;
        end else begin
          if (modOk) begin
            passes = passes + idxVal;
          end
          if (passes != 32'h0 && insn[`LEN_HI:`LEN_LO] != 8'h00) begin
            loop_d = scl_pkg::LOOPING;
            bodyStart_d = pc_q + 20'h00001;
            bodyEnd_d = pc_q + {12'h000, insn[`LEN_HI:`LEN_LO]};
            passLeft_d = passes;
          end
        end
      end else if (isJump) begin
        if (!inRange) begin
          events[`ST_RANGE] = 1'b1;
        end else begin
          pc_d = target;
          loop_d = scl_pkg::IDLE;
          passLeft_d = 32'h0;
        end
      end else begin
        // Body instructions run as they would outside a loop.
        if (aluW) begin
          regWr = 1'b1;
          if (opc == `OP_PLUS_ONE || opc == `OP_MINUS_ONE) begin
            carry_d = aluC;
            overflow_flag_d = aluV;
          end
        end
        if (loop_q == scl_pkg::LOOPING && pc_q == bodyEnd_q) begin
          if (passLeft_q > 32'h1) begin
            passLeft_d = passLeft_q - 32'h1;
            pc_d = bodyStart_q;
          end else begin
            passLeft_d = 32'h0;
            loop_d = scl_pkg::IDLE;
            events[`ST_LOOPEND] = 1'b1;
          end
        end
      end
      events[`ST_CARRY] = regWr & carry_d & (opc != `OP_XNOR_REGS) & (opc != `OP_XNOR_LIT);
      events[`ST_OVERFLOW_FLAG] = regWr & overflow_flag_d & (opc != `OP_XNOR_REGS) & (opc != `OP_XNOR_LIT);
    end
  end

  // ****************************************
  // Register file and bus registers
  // ****************************************
  logic busRegWr;
  assign busRegWr = wr && (wb_adr_i >= `A_REGS) && (wb_adr_i < `A_REGS + `REGS_SPAN);

  // Bus writes, status with write-one-to-clear where a new event wins.
  always_comb begin
    blkLo_d = blkLo_q;
    blkHi_d = blkHi_q;
    mask_d = mask_q;
    stat_d = stat_q | events;
    ack_d = req;
    rdat_d = 32'h0;
    if (wr) begin
      if (wb_adr_i == `A_STAT) begin
        stat_d = (stat_q & ~wb_dat_i[`ST_W-1:0]) | events;
      end else if (wb_adr_i == `A_MASK) begin
        mask_d = wb_dat_i[`ST_W-1:0];
      end else if (wb_adr_i == `A_BLKLO) begin
        blkLo_d = wb_dat_i[19:0];
      end else if (wb_adr_i == `A_BLKHI) begin
        blkHi_d = wb_dat_i[19:0];
      end
    end
    if (req && !wb_we_i) begin
      if (wb_adr_i == `A_CTRL) begin
        rdat_d = {30'h0, overflow_flag_q, carry_q};
      end else if (wb_adr_i == `A_PC) begin
        rdat_d = {12'h000, pc_q};
      end else if (wb_adr_i == `A_STAT) begin
        rdat_d = {27'h0, stat_q};
      end else if (wb_adr_i == `A_MASK) begin
        rdat_d = {27'h0, mask_q};
      end else if (wb_adr_i == `A_BLKLO) begin
        rdat_d = {12'h000, blkLo_q};
      end else if (wb_adr_i == `A_BLKHI) begin
        rdat_d = {12'h000, blkHi_q};
      end else if (wb_adr_i == `A_LOOP) begin
        rdat_d = passLeft_q;
      end else if (wb_adr_i >= `A_REGS && wb_adr_i < `A_REGS + `REGS_SPAN) begin
        rdat_d = regs_q[wb_adr_i[5:2]];
      end else begin
        rdat_d = 32'h0;
      end
    end
    irq_d = |(stat_d & mask_d);
  end

  // All state registers; clock enable freezes everything.
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_q <= 20'h0;
      loop_q <= scl_pkg::IDLE;
      bodyStart_q <= 20'h0;
      bodyEnd_q <= 20'h0;
      passLeft_q <= 32'h0;
      carry_q <= 1'b0;
      overflow_flag_q <= 1'b0;
      blkLo_q <= 20'h0;
      blkHi_q <= 20'hFFFFF;
      stat_q <= '0;
      mask_q <= '0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
      irq_q <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= 32'h0;
      end
    end else if (ce) begin
      pc_q <= pc_d;
      loop_q <= loop_d;
      bodyStart_q <= bodyStart_d;
      bodyEnd_q <= bodyEnd_d;
      passLeft_q <= passLeft_d;
      carry_q <= carry_d;
      overflow_flag_q <= overflow_flag_d;
      blkLo_q <= blkLo_d;
      blkHi_q <= blkHi_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      irq_q <= irq_d;
      if (regWr) begin
        regs_q[regWrSel] <= regWrData;
      end else if (busRegWr) begin
        regs_q[wb_adr_i[5:2]] <= wb_dat_i;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irq = irq_q;
  assign pcOut = pc_q;

  // ****************************************
  // Assertions
  // ****************************************
  property p_nest;
    @(posedge clk) disable iff (rst)
    (ce && insnPush && opc == `OP_REPEAT && loop_q == scl_pkg::LOOPING) |=> stat_q[`ST_NEST];
  endproperty
  a_nest: assert property (p_nest) else $error("nested repeat not flagged");

  property p_range;
    @(posedge clk) disable iff (rst)
    (ce && insnPush && isJump && !inRange) |=> (stat_q[`ST_RANGE] && pc_q == $past(pc_q) + 20'h1);
  endproperty
  a_range: assert property (p_range) else $error("out of block jump transferred");

  property p_early;
    @(posedge clk) disable iff (rst)
    (ce && insnPush && isJump && inRange) |=> (loop_q == scl_pkg::IDLE);
  endproperty
  a_early: assert property (p_early) else $error("jump did not end loop");

  property p_inc;
    @(posedge clk) disable iff (rst)
    (ce && insnPush && opc == `OP_PLUS_ONE) |=> (carry_q == ($past(priVal) == 32'hFFFFFFFF));
  endproperty
  a_inc: assert property (p_inc) else $error("increment carry wrong");

  property p_dec;
    @(posedge clk) disable iff (rst)
    (ce && insnPush && opc == `OP_MINUS_ONE) |=> (carry_q == ($past(priVal) != 32'h0));
  endproperty
  a_dec: assert property (p_dec) else $error("decrement carry wrong");

  property p_xnor;
    @(posedge clk) disable iff (rst)
    (ce && insnPush && opc == `OP_XNOR_REGS) |=> regs_q[$past(priSel)] == ~($past(priVal) ^ $past(idxVal));
  endproperty
  a_xnor: assert property (p_xnor) else $error("register xnor wrong");

  property p_ret;
    @(posedge clk) disable iff (rst)
    (ce && insnPush && opc == `OP_RETURN && inRange) |=> pc_q == $past(priVal[19:0]) + $past(insn[19:0]);
  endproperty
  a_ret: assert property (p_ret) else $error("return target wrong");

  property p_back;
    @(posedge clk) disable iff (rst)
    (ce && insnPush && !isJump && opc != `OP_REPEAT && loop_q == scl_pkg::LOOPING
      && pc_q == bodyEnd_q && passLeft_q > 32'h1) |=> pc_q == bodyStart_q;
  endproperty
  a_back: assert property (p_back) else $error("loop did not branch back");
endmodule

// *** tb/scalar_control_loop_unit_test.sv ***
// Self-checking bench for the scalar control loop unit.
// Assumes scl_map.svh and scl_pkg are compiled first; the bench is the only bus master.
`timescale 1ns/1ps
`include "scl_map.svh"
module scalar_control_loop_unit_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  scl_pkg::word_t dat = 32'h00000000;
  scl_pkg::word_t rdat;
  scl_pkg::word_t rd;
  logic ack;
  logic irq;
  logic [19:0] pcOut;
  logic [19:0] p;
  int n_mismatch = 0;
  int n_tests = 0;

  // Free-running 25 MHz clock.
  always #20 clk = ~clk;

  scalar_control_loop_unit dut_u (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(dat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .irq(irq),
    .pcOut(pcOut)
  );

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input scl_pkg::word_t got, input scl_pkg::word_t exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Bus access
  // ****************************************
  // The request is held until ack is seen at a rising edge; read data is taken at that edge.
  task automatic wbx(input logic w, input logic [7:0] a, input scl_pkg::word_t d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (ack !== 1'b1) begin
      n_mismatch++;
      $display("BAD t=%0t no bus answer", $time);
      report_and_stop();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input scl_pkg::word_t d);
    wbx(1'b1, a, d);
  endtask

  task automatic rdr(input logic [7:0] a);
    wbx(1'b0, a, 32'h00000000);
  endtask

  function automatic logic [7:0] ra(input int n);
    return 8'(`A_REGS + n * 4);
  endfunction

  function automatic scl_pkg::word_t mk(input logic [4:0] op, input logic [3:0] pr,
                                        input logic [3:0] ix, input logic [18:0] lo);
    return {op, pr, ix, lo};
  endfunction

  task automatic push(input scl_pkg::word_t insn);
    wr(`A_INSN, insn);
  endtask

  task automatic chkPc(input logic [19:0] exp, input string what);
    chk({12'h000, pcOut}, {12'h000, exp}, what);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Reset state, an unmapped read and a partial write that must be ignored.
  task automatic t_reset;
    chkPc(20'h00000, "pc after reset");
    chk({31'h00000000, irq}, 32'h00000000, "irq after reset");
    rdr(8'h20);
    chk(rd, 32'h00000000, "unmapped read");
    sel <= 4'h3;
    wr(ra(1), 32'hFFFFFFFF);
    sel <= 4'hF;
    rdr(ra(1));
    chk(rd, 32'h00000000, "partial write ignored");
    $display("test reset done");
  endtask

  // Clock enable low freezes the block: a pending push waits and nothing moves.
  task automatic t_hold;
    p = pcOut;
    ce <= 1'b0;
    fork
      push(mk(`OP_PLUS_ONE, 4'h8, 4'h0, 19'h00000));
      begin
        repeat (4) @(posedge clk);
        chkPc(p, "pc frozen while disabled");
        chk({31'h00000000, ack}, 32'h00000000, "no answer while disabled");
        ce <= 1'b1;
      end
    join
    chkPc(p + 20'h00001, "push runs once enabled");
    rdr(ra(8));
    chk(rd, 32'h00000001, "register stepped once");
    $display("test hold done");
  endtask

  // Both equivalence forms; the literal is widened with zeros.
  task automatic t_xnor;
    wr(ra(3), 32'h0F0F00FF);
    wr(ra(4), 32'h00FF0F0F);
    wr(ra(6), 32'h12345678);
    p = pcOut;
    push(mk(`OP_XNOR_REGS, 4'h3, 4'h4, 19'h00000));
    push(mk(`OP_XNOR_LIT, 4'h6, 4'h0, 19'h0ABCD));
    rdr(ra(3));
    chk(rd, ~(32'h0F0F00FF ^ 32'h00FF0F0F), "xnor regs");
    rdr(ra(6));
    chk(rd, ~(32'h12345678 ^ 32'h0000ABCD), "xnor literal");
    chkPc(p + 20'h00002, "pc steps per instruction");
    $display("test xnor done");
  endtask

  // Increment and decrement at the carry boundaries.
  task automatic t_step;
    scl_pkg::word_t iv[4];
    scl_pkg::word_t ev[4];
    logic [4:0] op[4];
    logic cv[4];
    logic ov[4];
    iv = '{32'hFFFFFFFF, 32'h00000005, 32'h00000000, 32'h80000000};
    ev = '{32'h00000000, 32'h00000006, 32'hFFFFFFFF, 32'h7FFFFFFF};
    op = '{`OP_PLUS_ONE, `OP_PLUS_ONE, `OP_MINUS_ONE, `OP_MINUS_ONE};
    cv = '{1'b1, 1'b0, 1'b0, 1'b1};
    // Of these four cases, signed overflow appears only when -1 crosses from the most negative value.
    ov = '{1'b0, 1'b0, 1'b0, 1'b1};
    for (int k = 0; k < 4; k++) begin
      wr(ra(7), iv[k]);
      push(mk(op[k], 4'h7, 4'h0, 19'h00000));
      rdr(ra(7));
      chk(rd, ev[k], "step result");
      rdr(`A_CTRL);
      chk({31'h00000000, rd[0]}, {31'h00000000, cv[k]}, "carry flag");
      chk({31'h00000000, rd[1]}, {31'h00000000, ov[k]}, "overflow flag");
    end
    $display("test step done");
  endtask

  // Jump with modifier, return with offset, out-of-block jump and its interrupt.
  task automatic t_jump;
    wr(ra(2), 32'h00000003);
    push(mk(`OP_JUMP, 4'h0, 4'h2, 19'h00100));
    chkPc(20'h00103, "jump plus modifier");
    wr(ra(0), 32'hFFF00010);
    push(mk(`OP_RETURN, 4'h0, 4'h0, 19'h00005));
    chkPc(20'h00015, "return low bits plus offset");
    wr(`A_BLKHI, 32'h00000200);
    wr(`A_MASK, 32'h00000002);
    push(mk(`OP_JUMP, 4'h0, 4'h0, 19'h00300));
    chkPc(20'h00016, "no transfer out of block");
    rdr(`A_STAT);
    chk({31'h00000000, rd[`ST_RANGE]}, 32'h00000001, "range error");
    chk({31'h00000000, irq}, 32'h00000001, "irq unmasked");
    wr(`A_MASK, 32'h00000000);
    rdr(`A_STAT);
    chk({31'h00000000, irq}, 32'h00000000, "irq masked");
    wr(`A_STAT, 32'h0000001F);
    rdr(`A_STAT);
    chk({31'h00000000, rd[`ST_RANGE]}, 32'h00000000, "status cleared");
    wr(`A_BLKHI, 32'h000FFFFF);
    $display("test jump done");
  endtask

  // Two passes from count plus modifier, then a nested repeat and an early exit.
  task automatic t_loop;
    wr(ra(1), 32'h00000001);
    wr(ra(5), 32'h00000000);
    p = pcOut;
    push(mk(`OP_REPEAT, 4'h0, 4'h1, {11'd1, 8'd2}));
    chkPc(p + 20'h00001, "body starts after repeat");
    // The body holds plain steps only.
    push(mk(`OP_PLUS_ONE, 4'h5, 4'h0, 19'h00000));
    chkPc(p + 20'h00002, "first body step");
    push(mk(`OP_PLUS_ONE, 4'h5, 4'h0, 19'h00000));
    chkPc(p + 20'h00001, "branch back");
    push(mk(`OP_PLUS_ONE, 4'h5, 4'h0, 19'h00000));
    push(mk(`OP_PLUS_ONE, 4'h5, 4'h0, 19'h00000));
    chkPc(p + 20'h00003, "fall through after last pass");
    rdr(ra(5));
    chk(rd, 32'h00000004, "body ran twice");
    rdr(`A_STAT);
    chk({31'h00000000, rd[`ST_LOOPEND]}, 32'h00000001, "loop end event");
    wr(`A_STAT, 32'h0000001F);
    push(mk(`OP_REPEAT, 4'h0, 4'h0, {11'd3, 8'd2}));
    push(mk(`OP_REPEAT, 4'h0, 4'h0, {11'd3, 8'd2}));
    rdr(`A_STAT);
    chk({31'h00000000, rd[`ST_NEST]}, 32'h00000001, "nested repeat error");
    push(mk(`OP_JUMP, 4'h0, 4'h0, 19'h00050));
    chkPc(20'h00050, "jump inside body");
    push(mk(`OP_PLUS_ONE, 4'h5, 4'h0, 19'h00000));
    push(mk(`OP_PLUS_ONE, 4'h5, 4'h0, 19'h00000));
    chkPc(20'h00052, "loop ended early");
    rdr(`A_LOOP);
    chk(rd, 32'h00000000, "no passes left");
    // A fresh repeat after the early exit must start cleanly, not count as nested.
    wr(`A_STAT, 32'h0000001F);
    push(mk(`OP_REPEAT, 4'h0, 4'h0, {11'd1, 8'd1}));
    push(mk(`OP_PLUS_ONE, 4'h5, 4'h0, 19'h00000));
    rdr(`A_STAT);
    chk({31'h00000000, rd[`ST_NEST]}, 32'h00000000, "loop left after jump");
    chk({31'h00000000, rd[`ST_LOOPEND]}, 32'h00000001, "single pass ends");
    $display("test loop done");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_hold();
    t_xnor();
    t_step();
    t_jump();
    t_loop();
    report_and_stop();
  end
endmodule
